// file: verilog/cifs_image_bank.sv
/*
 * Eight-channel image bank: eight configuration words in, eight shared
 * data/status words out, a type word and a word-count word.
 * Assumes a same-clock host port with one-cycle strobes and converter
 * samples already on this clock.
 */
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// (RULE1) each configuration word steers its channel only
// (RULE2) eight input words, each data or status
// (RULE3) configuration bit picks status or data
// (RULE4) status echoes latest accepted configuration
// (RULE5) status valid only enabled with valid configuration
// (RULE6) per-channel rate: 10, 50, 60, 250 Hz
// (RULE7) cut-off follows rate selection
// (RULE8) settling lasts three rate periods
// (RULE9) step response: 95 percent, fast inputs attenuated
// (RULE10) kept resolution depends on rate
// (RULE11) lower rate: more rejection, slower update
// (RULE12) type code tells host the word counts
// (RULE13) host addresses words by slot and index
// (RULE14) after reset channels disabled, words read zero

module cifs_image_bank
#(
    parameter int unsigned      STEP_CYC_10    = cifs_pkg::STEP_MS_10 * cifs_pkg::CLOCK_KHZ,
    parameter int unsigned      STEP_CYC_50    = cifs_pkg::STEP_MS_50 * cifs_pkg::CLOCK_KHZ,
    parameter int unsigned      STEP_CYC_60    = cifs_pkg::STEP_MS_60 * cifs_pkg::CLOCK_KHZ,
    parameter int unsigned      STEP_CYC_250   = cifs_pkg::STEP_MS_250 * cifs_pkg::CLOCK_KHZ,
    // arbitrary value, not any real part's code
    parameter logic [15:0]      MODULE_TYPE_ID = 16'h0A5C
)
(
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire cifs_pkg::cifs_addr_t address,
    input  wire cifs_pkg::cifs_word_t writeData,
    input  wire logic                 writeStrobe,
    input  wire logic                 readStrobe,
    input  wire cifs_pkg::cifs_word_t sampleData [cifs_pkg::CHANNELS],
    input  wire logic [7:0]           sampleValid,
    output cifs_pkg::cifs_word_t      readData,
    output logic [7:0]                chanOn,
    output cifs_pkg::cifs_rate_t      chanRate [cifs_pkg::CHANNELS]
);
    import cifs_pkg::*;

    cifs_word_t cfgRaw     [CHANNELS];
    cifs_word_t cfgActive  [CHANNELS];
    cifs_word_t next_cfgRaw    [CHANNELS];
    cifs_word_t next_cfgActive [CHANNELS];
    logic [7:0] cfgOk;
    logic [7:0] next_cfgOk;
    logic [7:0] next_chanOn;
    cifs_rate_t next_chanRate [CHANNELS];
    cifs_word_t next_readData;

    logic [7:0] wrValid;
    logic [7:0] cfgLoad;
    logic [7:0] actEnable;
    logic [7:0] actStatusSel;
    cifs_rate_t actRate   [CHANNELS];
    cifs_word_t filtered  [CHANNELS];
    cifs_word_t inWord    [CHANNELS];
    cifs_word_t statusWord[CHANNELS];
    logic [7:0] settled;
    logic       wrIsCfg;
    logic       rdIsIn;
    logic [2:0] chanIdx;

    // channel index taken from the low bits; only the range decode differs
    assign chanIdx = address[2:0];
    assign wrIsCfg = writeStrobe && (address >= CFG_BASE) && (address < INWORD_BASE);
    assign rdIsIn  = (address >= INWORD_BASE) && (address < TYPE_ID_ADDR);

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++)
        begin : gChan
            logic wrCheckValid;

            cifs_cfg_check uWrCheck
            (
                .cfgWord      (writeData),
                .cfgValid     (wrCheckValid),
                .cfgEnable    (),
                .cfgStatusSel (),
                .cfgRate      ()
            );

            cifs_cfg_check uActCheck
            (
                .cfgWord      (cfgActive[g]),
                .cfgValid     (),
                .cfgEnable    (actEnable[g]),
                .cfgStatusSel (actStatusSel[g]),
                .cfgRate      (actRate[g])
            );

            // only the addressed word is touched; the others keep theirs
            assign wrValid[g] = wrCheckValid;
            assign cfgLoad[g] = wrIsCfg && (chanIdx == 3'(g)) && wrCheckValid; // RULE1

            cifs_chan_filter
            #(
                .STEP_CYC_10  (STEP_CYC_10),
                .STEP_CYC_50  (STEP_CYC_50),
                .STEP_CYC_60  (STEP_CYC_60),
                .STEP_CYC_250 (STEP_CYC_250)
            )
            uFilter
            (
                .clock       (clock),
                .reset       (reset),
                .restart     (cfgLoad[g]),
                .enable      (chanOn[g]),
                .rate        (chanRate[g]), // RULE6 RULE11
                .sampleValid (sampleValid[g]),
                .sample      (sampleData[g]),
                .filtered    (filtered[g]),
                .settled     (settled[g])
            );

            always_comb
            begin
                statusWord[g] = RESET_WORD;
                statusWord[g][CFG_ECHO_W-1:0] = cfgActive[g][CFG_ECHO_W-1:0]; // RULE4
                statusWord[g][STS_SETTLED_BIT] = settled[g];
                statusWord[g][STS_VALID_BIT] = cfgOk[g];
                if (!cfgOk[g] || !actEnable[g])
                    inWord[g] = RESET_WORD; // RULE5 RULE14
                else if (actStatusSel[g])
                    inWord[g] = statusWord[g]; // RULE2 RULE3
                else
                    inWord[g] = filtered[g]; // RULE2 RULE3
            end
        end
    endgenerate

    always_comb
    begin
        next_cfgOk = cfgOk;
        for (int i = 0; i < CHANNELS; i++)
        begin
            next_cfgRaw[i]    = cfgRaw[i];
            next_cfgActive[i] = cfgActive[i];
            if (wrIsCfg && (chanIdx == 3'(i)))
            begin
                next_cfgRaw[i] = writeData;
                // a rejected word leaves the channel without valid status
                next_cfgOk[i] = wrValid[i]; // RULE5
                if (wrValid[i])
                    next_cfgActive[i] = writeData; // RULE1 RULE4
            end
            next_chanOn[i]   = next_cfgOk[i] && next_cfgActive[i][CFG_EN_BIT];
            next_chanRate[i] = cifs_rate_t'(next_cfgActive[i][CFG_RATE_LSB+1:CFG_RATE_LSB]);
        end
    end

    always_comb
    begin
        next_readData = RESET_WORD;
        if (readStrobe)
        begin
            if (address < INWORD_BASE)
                next_readData = cfgRaw[chanIdx];
            else if (rdIsIn)
                next_readData = inWord[chanIdx]; // RULE2
            else if (address == TYPE_ID_ADDR)
                next_readData = MODULE_TYPE_ID; // RULE12
            else if (address == WORD_CNT_ADDR)
                next_readData = {IMAGE_WORDS, IMAGE_WORDS}; // RULE12
            else
                next_readData = RESET_WORD;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                cfgRaw[i]    <= RESET_WORD;
                cfgActive[i] <= RESET_WORD;
                chanRate[i]  <= RATE_10HZ;
            end
            cfgOk    <= 8'h00; // RULE14
            chanOn   <= 8'h00; // RULE14
            readData <= RESET_WORD;
        end
        else
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                cfgRaw[i]    <= next_cfgRaw[i];
                cfgActive[i] <= next_cfgActive[i];
                chanRate[i]  <= next_chanRate[i]; // RULE6
            end
            cfgOk    <= next_cfgOk;
            chanOn   <= next_chanOn;
            readData <= next_readData;
        end
    end

    property p_readOneCycle;
        @(posedge clock) disable iff (reset)
        !readStrobe |=> (readData == RESET_WORD);
    endproperty
    a_readOneCycle: assert property (p_readOneCycle) // RULE2
        else $error("read data present without a read");

    property p_cfgEnables;
        @(posedge clock) disable iff (reset)
        (writeStrobe && (address == CFG_BASE) && (writeData[DATA_W-1:CFG_RSVD_LSB] == '0))
            |=> (chanOn[0] == $past(writeData[CFG_EN_BIT]));
    endproperty
    a_cfgEnables: assert property (p_cfgEnables) // RULE1
        else $error("channel 0 enable does not follow its configuration");

    property p_otherUntouched;
        @(posedge clock) disable iff (reset)
        (writeStrobe && (address == 5'h01)) |=> $stable(cfgActive[0]) && $stable(cfgOk[0]);
    endproperty
    a_otherUntouched: assert property (p_otherUntouched) // RULE1
        else $error("write to channel 1 altered channel 0");

    property p_typeId;
        @(posedge clock) disable iff (reset)
        (readStrobe && (address == TYPE_ID_ADDR)) |=> (readData == MODULE_TYPE_ID);
    endproperty
    a_typeId: assert property (p_typeId) // RULE12
        else $error("type code read back wrong");

    property p_resetIdle;
        @(posedge clock)
        reset |=> (chanOn == 8'h00) && (cfgOk == 8'h00) && (readData == RESET_WORD);
    endproperty
    a_resetIdle: assert property (p_resetIdle) // RULE14
        else $error("channels not idle after reset");

    property p_disabledZero;
        @(posedge clock) disable iff (reset)
        (readStrobe && (address == INWORD_BASE) && !(cfgOk[0] && actEnable[0]))
            |=> (readData == RESET_WORD);
    endproperty
    a_disabledZero: assert property (p_disabledZero) // RULE5
        else $error("disabled channel returned a nonzero word");

    property p_statusEcho;
        @(posedge clock) disable iff (reset)
        (readStrobe && (address == INWORD_BASE) && cfgOk[0] && actEnable[0] && actStatusSel[0])
            |=> (readData[CFG_ECHO_W-1:0] == $past(cfgActive[0][CFG_ECHO_W-1:0]))
                && readData[STS_VALID_BIT];
    endproperty
    a_statusEcho: assert property (p_statusEcho) // RULE4
        else $error("status word does not echo configuration");

    property p_dataSelect;
        @(posedge clock) disable iff (reset)
        (readStrobe && (address == INWORD_BASE) && cfgOk[0] && actEnable[0] && !actStatusSel[0])
            |=> (readData == $past(filtered[0]));
    endproperty
    a_dataSelect: assert property (p_dataSelect) // RULE3
        else $error("data word not returned when data selected");

    property p_rateFollows;
        @(posedge clock) disable iff (reset)
        (writeStrobe && (address == 5'h02) && (writeData[DATA_W-1:CFG_RSVD_LSB] == '0))
            |=> (chanRate[2] == cifs_rate_t'($past(writeData[CFG_RATE_LSB+1:CFG_RATE_LSB])));
    endproperty
    a_rateFollows: assert property (p_rateFollows) // RULE6
        else $error("channel 2 rate does not follow its configuration");

    property p_invalidDrops;
        @(posedge clock) disable iff (reset)
        (writeStrobe && (address == 5'h03) && (writeData[DATA_W-1:CFG_RSVD_LSB] != '0))
            |=> !chanOn[3] && !cfgOk[3] && (cfgRaw[3] == $past(writeData));
    endproperty
    a_invalidDrops: assert property (p_invalidDrops) // RULE5
        else $error("rejected word left channel 3 valid");

    property p_wordCount;
        @(posedge clock) disable iff (reset)
        (readStrobe && (address == WORD_CNT_ADDR)) |=> (readData == {IMAGE_WORDS, IMAGE_WORDS});
    endproperty
    a_wordCount: assert property (p_wordCount) // RULE12
        else $error("word count read back wrong");

    property p_inWordReadOnly;
        @(posedge clock) disable iff (reset)
        (writeStrobe && (address == INWORD_BASE)) |=> $stable(cfgRaw[0]) && $stable(chanOn);
    endproperty
    a_inWordReadOnly: assert property (p_inWordReadOnly) // RULE1
        else $error("write to an input word changed a configuration");

endmodule

`default_nettype wire

// file: verilog/cifs_pkg.sv
/*
 * Shared constants for the eight-channel image and filter select block:
 * word map, configuration and status fields, filter rate table, timing.
 * Assumes a single 100 MHz clock; no timescale here.
 */
package cifs_pkg;

    localparam int CHANNELS = 8;
    localparam int DATA_W   = 16;
    localparam int ADDR_W   = 5;
    localparam int ACC_W    = DATA_W + 8;

    typedef logic [ADDR_W-1:0] cifs_addr_t;
    typedef logic [DATA_W-1:0] cifs_word_t;
    typedef enum logic [1:0] {RATE_10HZ, RATE_50HZ, RATE_60HZ, RATE_250HZ} cifs_rate_t;

    // word map, one index per word
    localparam cifs_addr_t CFG_BASE      = 5'h00;
    localparam cifs_addr_t INWORD_BASE   = 5'h08;
    localparam cifs_addr_t TYPE_ID_ADDR  = 5'h10;
    localparam cifs_addr_t WORD_CNT_ADDR = 5'h11;

    // configuration word fields
    localparam int CFG_EN_BIT    = 0;
    localparam int CFG_STSEL_BIT = 1;
    localparam int CFG_RATE_LSB  = 2;
    localparam int CFG_RSVD_LSB  = 4;
    localparam int CFG_ECHO_W    = 4;

    // status word fields above the echoed configuration
    localparam int STS_SETTLED_BIT = 4;
    localparam int STS_VALID_BIT   = 5;

    localparam cifs_word_t RESET_WORD  = 16'h0000;
    localparam logic [7:0] IMAGE_WORDS = 8'h08;

    // filter rate table
    localparam int CLOCK_KHZ      = 100000;
    localparam int STEP_PERIODS   = 3;
    localparam int STEP_MS_10     = 300;
    localparam int STEP_MS_50     = 60;
    localparam int STEP_MS_60     = 50;
    localparam int STEP_MS_250    = 12;
    localparam int CUTOFF_CHZ_10  = 262;
    localparam int CUTOFF_CHZ_50  = 1310;
    localparam int CUTOFF_CHZ_60  = 1572;
    localparam int CUTOFF_CHZ_250 = 6550;
    localparam int RES_TENTHS_10  = 205;
    localparam int RES_TENTHS_50  = 190;
    localparam int RES_TENTHS_60  = 190;
    localparam int RES_TENTHS_250 = 55;

    // smoothing shift per rate: wider band, smaller shift
    localparam logic [2:0] SHIFT_10  = 3'h4;
    localparam logic [2:0] SHIFT_50  = 3'h2;
    localparam logic [2:0] SHIFT_60  = 3'h2;
    localparam logic [2:0] SHIFT_250 = 3'h1;

    // kept data bits; rates above the word width keep all of it
    localparam cifs_word_t RES_MASK_FULL = 16'hFFFF;
    localparam cifs_word_t RES_MASK_250  =
        16'(RES_MASK_FULL << (DATA_W - (RES_TENTHS_250 + 9) / 10));

endpackage

// file: verilog/cifs_cfg_check.sv
/*
 * Decodes one configuration word into enable, select, rate and validity.
 * Purely combinational; the caller registers whatever it keeps.
 */
`timescale 1ns/100ps
`default_nettype none

module cifs_cfg_check
(
    input  wire cifs_pkg::cifs_word_t cfgWord,
    output logic                      cfgValid,
    output logic                      cfgEnable,
    output logic                      cfgStatusSel,
    output cifs_pkg::cifs_rate_t      cfgRate
);
    import cifs_pkg::*;

    always_comb
    begin
        // reserved bits set mean a word the block does not understand
        cfgValid     = (cfgWord[DATA_W-1:CFG_RSVD_LSB] == '0);
        cfgEnable    = cfgWord[CFG_EN_BIT];
        cfgStatusSel = cfgWord[CFG_STSEL_BIT];
        cfgRate      = cifs_rate_t'(cfgWord[CFG_RATE_LSB+1:CFG_RATE_LSB]);
    end

endmodule

`default_nettype wire

// file: verilog/cifs_chan_filter.sv
/*
 * One channel's digital filter: first-order smoothing of converter
 * samples plus a settling timer of three filter periods.
 * Samples arrive on the block clock; enable and rate come registered.
 */
`timescale 1ns/100ps
`default_nettype none

module cifs_chan_filter
#(
    parameter int unsigned STEP_CYC_10  = 1,
    parameter int unsigned STEP_CYC_50  = 1,
    parameter int unsigned STEP_CYC_60  = 1,
    parameter int unsigned STEP_CYC_250 = 1
)
(
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire logic                 restart,
    input  wire logic                 enable,
    input  wire cifs_pkg::cifs_rate_t rate,
    input  wire logic                 sampleValid,
    input  wire cifs_pkg::cifs_word_t sample,
    output cifs_pkg::cifs_word_t      filtered,
    output logic                      settled
);
    import cifs_pkg::*;

    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] next_acc;
    logic [31:0]      settleCount;
    logic [31:0]      next_settleCount;
    logic [31:0]      stepCyc;
    logic [2:0]       shift;
    cifs_word_t       resMask;
    logic signed [ACC_W:0] diff;

    always_comb
    begin
        case (rate)
            RATE_10HZ:  begin stepCyc = STEP_CYC_10;  shift = SHIFT_10;  end
            RATE_50HZ:  begin stepCyc = STEP_CYC_50;  shift = SHIFT_50;  end
            RATE_60HZ:  begin stepCyc = STEP_CYC_60;  shift = SHIFT_60;  end
            default:    begin stepCyc = STEP_CYC_250; shift = SHIFT_250; end
        endcase
        resMask = (rate == RATE_250HZ) ? RES_MASK_250 : RES_MASK_FULL; // RULE10
        diff = $signed({1'b0, sample, 8'h00}) - $signed({1'b0, acc});
        next_acc = acc;
        next_settleCount = settleCount;
        if (!enable || restart)
        begin
            next_acc = '0;
            next_settleCount = '0; // RULE8
        end
        else
        begin
            if (sampleValid)
                next_acc = acc + ACC_W'(diff >>> shift); // RULE7 RULE9
            if (settleCount < stepCyc)
                next_settleCount = settleCount + 32'h00000001; // RULE8
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            acc         <= '0;
            settleCount <= '0;
            filtered    <= RESET_WORD;
            settled     <= 1'b0;
        end
        else
        begin
            acc         <= next_acc;
            settleCount <= next_settleCount;
            filtered    <= next_acc[ACC_W-1:8] & resMask;
            settled     <= enable && !restart && (next_settleCount >= stepCyc);
        end
    end

    property p_settleWait;
        @(posedge clock) disable iff (reset)
        settled |-> (settleCount >= stepCyc);
    endproperty
    a_settleWait: assert property (p_settleWait) // RULE8
        else $error("settled flag raised before the step time");

    property p_trackSample;
        @(posedge clock) disable iff (reset)
        // a difference of one is lost in the halving, so it cannot move the sum
        (enable && !restart && sampleValid && (diff > 1) && (shift == 3'h1))
            |=> (acc > $past(acc));
    endproperty
    a_trackSample: assert property (p_trackSample) // RULE9
        else $error("filter did not move toward a higher sample");

endmodule

`default_nettype wire

// file: testbench/cifs_host_model.sv
/*
 * Host-side model of the image bank's word port: one-cycle write and read
 * strobes, word index only. Assumes the bench owns the block clock.
 */
`timescale 1ns/100ps
`default_nettype none

module cifs_host_model
(
    input  wire logic                 clock,
    output cifs_pkg::cifs_addr_t      address,
    output cifs_pkg::cifs_word_t      writeData,
    output logic                      writeStrobe,
    output logic                      readStrobe,
    input  wire cifs_pkg::cifs_word_t readData
);
    import cifs_pkg::*;

    initial
    begin
        address     = '0;
        writeData   = '0;
        writeStrobe = 1'b0;
        readStrobe  = 1'b0;
    end

    // word index only; slot part is decoded before this port
    task automatic writeWord(input cifs_addr_t a, input cifs_word_t d);
        @(posedge clock);
        address     <= a;
        writeData   <= d;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
        // released lines show garbage, not the last value
        address     <= ~a;
        writeData   <= ~d;
        #1;
    endtask

    // strobes never overlap: each task owns the port alone
    task automatic readWord(input cifs_addr_t a, output cifs_word_t d,
                            output cifs_word_t after);
        @(posedge clock);
        address    <= a;
        readStrobe <= 1'b1;
        @(posedge clock);
        readStrobe <= 1'b0;
        address    <= ~a;
        #1;
        d = readData;
        @(posedge clock);
        #1;
        after = readData;
    endtask

endmodule

`default_nettype wire

// file: testbench/channel_image_and_filter_select_tb.sv
/*
 * Self-checking bench for the image bank: reset state, status echo and
 * settling, filtered data against an integer model, refusals.
 * Assumes short settle counts passed in as parameters.
 */
`timescale 1ns/100ps
`default_nettype none

module channel_image_and_filter_select_tb;
    import cifs_pkg::*;

    localparam int unsigned S10 = 40;
    localparam int unsigned S50 = 30;
    localparam int unsigned S60 = 24;
    localparam int unsigned S250 = 16;
    // arbitrary value, no real part's code
    localparam logic [15:0] TYPE_ID = 16'h3C5A;

    logic       clock;
    logic       reset;
    cifs_addr_t address;
    cifs_word_t writeData;
    logic       writeStrobe;
    logic       readStrobe;
    cifs_word_t sampleData [CHANNELS];
    logic [7:0] sampleValid;
    cifs_word_t readData;
    logic [7:0] chanOn;
    cifs_rate_t chanRate [CHANNELS];
    int         mismatches;
    int         nCompared;
    int         acc [CHANNELS];
    int         sv [CHANNELS];
    int         rt [CHANNELS];
    cifs_word_t cfg;

    cifs_image_bank #(.STEP_CYC_10(S10), .STEP_CYC_50(S50), .STEP_CYC_60(S60),
                      .STEP_CYC_250(S250), .MODULE_TYPE_ID(TYPE_ID)) i_cifs_image_bank
    (
        .clock(clock), .reset(reset), .address(address), .writeData(writeData),
        .writeStrobe(writeStrobe), .readStrobe(readStrobe), .sampleData(sampleData),
        .sampleValid(sampleValid), .readData(readData), .chanOn(chanOn),
        .chanRate(chanRate)
    );

    cifs_host_model i_cifs_host_model
    (
        .clock(clock), .address(address), .writeData(writeData),
        .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData)
    );

    task automatic test_done;
        $display("compared %0d, mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input cifs_word_t seen, input cifs_word_t exp);
        nCompared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic rdChk(input cifs_addr_t a, input cifs_word_t exp);
        cifs_word_t d;
        cifs_word_t after;
        i_cifs_host_model.readWord(a, d, after);
        check(d, exp);
        check(after, 16'h0000);
    endtask

    // smoothing model: wider band, smaller shift
    function automatic int shiftOf(input int r);
        return r == 0 ? SHIFT_10 : r == 3 ? SHIFT_250 : SHIFT_50;
    endfunction

    function automatic cifs_word_t expData(input int c);
        cifs_word_t w;
        w = 16'(acc[c] >> 8);
        return rt[c] == 3 ? w & RES_MASK_250 : w;
    endfunction

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial
    begin
        #500000;
        mismatches++;
        test_done();
    end

    initial
    begin
        reset = 1'b1;
        sampleValid = 8'h00;
        foreach (sampleData[c]) sampleData[c] = 16'h0000;
        mismatches = 0;
        nCompared = 0;
        void'($urandom(32'h5678e5b7));
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        for (int a = 0; a < CHANNELS; a++)
        begin
            rdChk(CFG_BASE + 5'(a), 16'h0000);
            rdChk(INWORD_BASE + 5'(a), 16'h0000);
        end
        check(16'(chanOn), 16'h0000);
        rdChk(TYPE_ID_ADDR, TYPE_ID);
        rdChk(WORD_CNT_ADDR, {IMAGE_WORDS, IMAGE_WORDS});
        rdChk(5'h15, 16'h0000);
        // status mode, every rate on two channels
        for (int c = 0; c < CHANNELS; c++)
        begin
            cfg = 16'(((c % 4) << 2) | 3);
            i_cifs_host_model.writeWord(CFG_BASE + 5'(c), cfg);
            check(16'(chanOn), 16'((1 << (c + 1)) - 1));
            check(16'(chanRate[c]), 16'(c % 4));
            rdChk(INWORD_BASE + 5'(c), 16'h0020 | cfg);
            rdChk(CFG_BASE + 5'(c), cfg);
        end
        repeat (50) @(posedge clock);
        for (int c = 0; c < CHANNELS; c++)
            rdChk(INWORD_BASE + 5'(c), 16'h0030 | 16'(((c % 4) << 2) | 3));
        // data mode, random rates; rising samples keep the difference positive
        for (int c = 0; c < CHANNELS; c++)
        begin
            rt[c] = $urandom_range(0, 3);
            acc[c] = 0;
            sv[c] = $urandom_range(0, 16'h3FFF);
            i_cifs_host_model.writeWord(CFG_BASE + 5'(c), 16'((rt[c] << 2) | 1));
            check(16'(chanRate[c]), 16'(rt[c]));
        end
        repeat (20)
        begin
            @(posedge clock);
            for (int c = 0; c < CHANNELS; c++)
            begin
                sv[c] += $urandom_range(0, 255);
                sampleData[c] <= 16'(sv[c]);
                acc[c] += ((sv[c] << 8) - acc[c]) >> shiftOf(rt[c]);
            end
            sampleValid <= 8'hFF;
            @(posedge clock);
            sampleValid <= 8'h00;
            for (int c = 0; c < CHANNELS; c++) sampleData[c] <= ~16'(sv[c]);
        end
        repeat (3) @(posedge clock);
        for (int c = 0; c < CHANNELS; c++)
            rdChk(INWORD_BASE + 5'(c), expData(c));
        // reserved bits set: stored raw, channel drops out
        i_cifs_host_model.writeWord(CFG_BASE + 5'(3), 16'h0013);
        check(16'(chanOn[3]), 16'h0000);
        rdChk(CFG_BASE + 5'(3), 16'h0013);
        rdChk(INWORD_BASE + 5'(3), 16'h0000);
        // input words are read-only
        i_cifs_host_model.writeWord(INWORD_BASE, 16'hFFFF);
        rdChk(INWORD_BASE, expData(0));
        i_cifs_host_model.writeWord(CFG_BASE, 16'h0000);
        check(16'(chanOn[0]), 16'h0000);
        rdChk(INWORD_BASE, 16'h0000);
        // reset in mid-run: channel 1 still holds a data-mode word here
        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        #1;
        check(16'(chanOn), 16'h0000);
        check(16'(chanRate[1]), 16'h0000);
        rdChk(CFG_BASE + 5'(1), 16'h0000);
        rdChk(INWORD_BASE + 5'(1), 16'h0000);
        test_done();
    end

endmodule

`default_nettype wire
